// ===== inc/ftm_map.vh
// Constants for the fault trip manager: trip codes, classes and timing figures.
// Assumes a 10 MHz system clock; included by its bare name from rtl files.
//
// Notes on behaviour
// - Active trip is reported as a code 1 to 232 from a fixed map; a fatal fault shows code 0.
// - A new trip is taken only if idle or its class number is lower.
// - Class 1 fatal faults refuse reset, stop output, health relay and comms.
// - Class 2 faults, codes 217-232 and slot faults, clear only at power cycle.
// - Class 3 stored parameter fault resets only after a load defaults write.
// - Card and 24 V trips are class 4, reset after 1.0 s; card class 5 at power-up.
// - Autotune trips reset after 1.0 s, then run blocked until the drive is disabled.
// - Overcurrent trips are class 5 and refuse reset before 10.0 s.
// - Non-important trips stop the motor first when trip mode bit 0 is set.
// - Thermal model overheat stops first, but trips anyway after 10 s.
// - Undervoltage is class 6, ignores user reset, clears itself.
// - During undervoltage trip other functions run but the output stage stays off.
// - Undervoltage entry saves parameters unless low voltage supply mode is on.
// - Undervoltage clears above restart level unless another trip replaced it.
// - Supply source may change only while the undervoltage flag is one.
// - Undervoltage shows as active only when no other trip is active.
// - At power-up low supply raises undervoltage with no parameter save.
`ifndef FTM_MAP_VH
`define FTM_MAP_VH

// ****************************************************************
// Trip codes
// ****************************************************************
`define FTM_C_NONE       8'h00
`define FTM_C_DCLOW      8'h01
`define FTM_C_DCHIGH     8'h02
`define FTM_C_OUT_OC     8'h03
`define FTM_C_BRK_OC     8'h04
`define FTM_C_AUX24      8'h09
`define FTM_C_TUNE1      8'h0B
`define FTM_C_TUNE3      8'h0D
`define FTM_C_TUNE7      8'h11
`define FTM_C_TUNE       8'h12
`define FTM_C_SNS_TEMP   8'h18
`define FTM_C_DO_OVL     8'h1A
`define FTM_C_OVERHEAT   8'h1B
`define FTM_C_AIN2_LOSS  8'h1C
`define FTM_C_SER_LOSS   8'h1E
`define FTM_C_STORED     8'h1F
`define FTM_C_PH_LOSS    8'h20
`define FTM_C_MOD_BRK    8'h67
`define FTM_C_MOD_OUT    8'h68
`define FTM_C_MOD_DC     8'h6D
`define FTM_C_CARD_PROD  8'hAF
`define FTM_C_CARD_LO    8'hB1
`define FTM_C_CARD_HI    8'hBC
`define FTM_C_SLOT1_HF   8'hC8
`define FTM_C_SLOT2_HF   8'hCD
`define FTM_C_HF_LO      8'hD9
`define FTM_C_HF_HI      8'hE8

// ****************************************************************
// Priority classes
// ****************************************************************
`define FTM_CL_FATAL     3'h1
`define FTM_CL_NORESET   3'h2
`define FTM_CL_STORED    3'h3
`define FTM_CL_CARD      3'h4
`define FTM_CL_NORMAL    3'h5
`define FTM_CL_SELF      3'h6

// ****************************************************************
// Timing
// ****************************************************************
`define FTM_CLK_HZ       10000000
`define FTM_T_RESET_MS   1000
`define FTM_T_EXT_MS     10000
`define FTM_T_HEAT_MS    10000
`define FTM_CNT_W        27

`endif

// ===== rtl/ftm_timer.v
// Elapsed-time counter used for reset hold-off and stop timeouts.
// Assumes one clock; start restarts the count from zero.
`timescale 1ns/100ps
`include "ftm_map.vh"

module ftm_timer (
  input  wire                   sys_clk,  // System clock.
  input  wire                   sys_rst,  // Asynchronous reset, active high.
  input  wire                   start,    // Restart counting from zero.
  input  wire [`FTM_CNT_W-1:0]  limit,    // Cycles to elapse before done.
  output reg                    done_q    // Limit reached, held until start.
);

  reg [`FTM_CNT_W-1:0] cnt_q;

  // The count saturates so that a trip held for hours cannot wrap and
  // falsely report a short elapsed time.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= {`FTM_CNT_W{1'b0}};
      done_q <= 1'b0;
    end else if (start) begin
      cnt_q  <= {`FTM_CNT_W{1'b0}};
      done_q <= 1'b0;
    end else begin
      if (!done_q)
        cnt_q <= cnt_q + 1'b1;
      done_q <= (cnt_q + 1'b1 >= limit) | done_q;
    end
  end

endmodule // ftm_timer

// ===== rtl/ftm_top.v
// Fault trip manager: arbitration, reset hold-off and undervoltage handling.
// Assumes fault detectors deliver one-cycle trip pulses with a code, and
// that all inputs are synchronous to sys_clk.
`timescale 1ns/100ps
`include "ftm_map.vh"

module ftm_top #(
  parameter HOLD_STD_CYC = `FTM_T_RESET_MS * (`FTM_CLK_HZ / 1000), // 1.0 s hold-off.
  parameter HOLD_EXT_CYC = `FTM_T_EXT_MS * (`FTM_CLK_HZ / 1000),   // 10.0 s hold-off.
  parameter HEAT_CYC     = `FTM_T_HEAT_MS * (`FTM_CLK_HZ / 1000)   // Overheat stop wait.
) (
  input  wire       sys_clk,                        // System clock, 10 MHz.
  input  wire       sys_rst,                        // Asynchronous reset, active high.
  input  wire       trip_req,                       // Pulse: a detector reports a trip.
  input  wire [7:0] trip_req_code,                  // Code of the reported trip.
  input  wire       fatal_hw_fault_trip,            // Pulse: fatal hardware fault.
  input  wire [3:0] fatal_hw_num,                   // Fatal fault number minus one.
  input  wire       user_reset,                     // Pulse: user reset request.
  input  wire       defaults_written,               // Pulse: load defaults code written.
  input  wire [1:0] trip_mode_setting,              // Stop-before-trip mode.
  input  wire       motor_stopped,                  // Motor is at standstill.
  input  wire       powerup_done,                   // Power-up sequence has finished.
  input  wire       dc_below_threshold,             // DC bus under trip threshold.
  input  wire       dc_below_restart,               // DC bus under restart level.
  input  wire       low_voltage_supply_select,      // Request low voltage DC supply.
  input  wire       enable_input,                   // Hardware enable terminal.
  input  wire       output_enable_setting,          // Enable parameter.
  input  wire       control_word_enable,            // Enable bit of the control word.
  input  wire       run_request,                    // Sequencer wants the output stage on.
  output reg        trip_active_q,                  // A trip is latched.
  output reg  [7:0] active_trip_code_q,             // Serial code of the active trip.
  output reg  [2:0] active_class_q,                 // Class of the active trip.
  output reg  [3:0] fatal_num_q,                    // Number of a latched fatal fault.
  output reg        health_ok_q,                    // Health relay closed when high.
  output reg        comms_enable_q,                 // Serial comms allowed.
  output reg        output_stage_enable_q,          // Output stage enable.
  output reg        stop_req_q,                     // Ask the sequencer to stop the motor.
  output reg        param_save_q,                   // Pulse: save power-down parameters.
  output reg        undervoltage_condition_flag_q,  // DC bus is in undervoltage.
  output reg        lv_supply_active_q,             // Low voltage DC supply in use.
  output reg        run_inhibit_q                   // Run blocked after autotune reset.
);

  localparam ST_IDLE = 2'h0;
  localparam ST_STOP = 2'h1;

  localparam [`FTM_CNT_W-1:0] HOLD_STD = HOLD_STD_CYC[`FTM_CNT_W-1:0];
  localparam [`FTM_CNT_W-1:0] HOLD_EXT = HOLD_EXT_CYC[`FTM_CNT_W-1:0];
  localparam [`FTM_CNT_W-1:0] HEAT_LIM = HEAT_CYC[`FTM_CNT_W-1:0];

  reg  [1:0] pend_st_q;
  reg  [1:0] pend_st_d;
  reg  [7:0] pend_code_q;
  reg        ext_hold_q;
  reg        tune_trip_q;
  reg        defaults_seen_q;
  reg        init_q;
  reg        cand_valid;
  reg  [7:0] cand_code;
  reg  [2:0] cand_class;
  reg        cand_save;
  reg        accept;
  reg        reset_ok;
  wire       hold_done;
  wire       heat_done;
  wire       req_stop_first;
  wire       pend_fire;
  wire       uv_clear;
  wire       uv_rise;

  // ****************************************************************
  // Trip classification
  // ****************************************************************

  // Class of a serial code; card trips drop to class 5 while powering up.
  function [2:0] class_of;
    input [7:0] c;
    input       pu;
    begin
      if (c == `FTM_C_DCLOW)
        class_of = `FTM_CL_SELF;
      else if ((c >= `FTM_C_HF_LO && c <= `FTM_C_HF_HI) ||
               c == `FTM_C_SLOT1_HF || c == `FTM_C_SLOT2_HF)
        class_of = `FTM_CL_NORESET;
      else if (c == `FTM_C_STORED)
        class_of = `FTM_CL_STORED;
      else if (c == `FTM_C_AUX24)
        class_of = `FTM_CL_CARD;
      else if (c == `FTM_C_CARD_PROD ||
               (c >= `FTM_C_CARD_LO && c <= `FTM_C_CARD_HI))
        class_of = pu ? `FTM_CL_NORMAL : `FTM_CL_CARD;
      else
        class_of = `FTM_CL_NORMAL;
    end
  endfunction

  // Overcurrent codes need the long hold-off.
  function is_ext;
    input [7:0] c;
    begin
      is_ext = (c == `FTM_C_OUT_OC) || (c == `FTM_C_BRK_OC) ||
               (c == `FTM_C_MOD_OUT) || (c == `FTM_C_MOD_BRK) ||
               (c == `FTM_C_MOD_DC);
    end
  endfunction

  // Autotune codes block running after their reset.
  function is_tune;
    input [7:0] c;
    begin
      is_tune = (c >= `FTM_C_TUNE1 && c <= `FTM_C_TUNE3) ||
                (c == `FTM_C_TUNE7) || (c == `FTM_C_TUNE);
    end
  endfunction

  // Codes that bring the motor to rest before they latch.
  function stop_first;
    input [7:0] c;
    input       mode0;
    begin
      if (c == `FTM_C_PH_LOSS || c == `FTM_C_OVERHEAT)
        stop_first = 1'b1;
      else if ((c >= `FTM_C_SNS_TEMP && c <= `FTM_C_DO_OVL) ||
               (c >= `FTM_C_AIN2_LOSS && c <= `FTM_C_SER_LOSS))
        stop_first = mode0;
      else
        stop_first = 1'b0;
    end
  endfunction

  assign req_stop_first = stop_first(trip_req_code, trip_mode_setting[0]);

  // ****************************************************************
  // Stop-before-trip sequencer
  // ****************************************************************

  // One pending slot: a second stop-first trip while one waits is dropped,
  // which is harmless since the first one will trip the drive anyway.
  assign pend_fire = (pend_st_q == ST_STOP) &&
                     (motor_stopped ||
                      (pend_code_q == `FTM_C_OVERHEAT && heat_done));

  always @* begin
    pend_st_d = pend_st_q;
    case (pend_st_q)
      ST_IDLE: begin
        if (trip_req && req_stop_first)
          pend_st_d = ST_STOP;
      end
      ST_STOP: begin
        if (pend_fire)
          pend_st_d = ST_IDLE;
      end
      default: begin
        pend_st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_st_q   <= ST_IDLE;
      pend_code_q <= `FTM_C_NONE;
      stop_req_q  <= 1'b0;
    end else begin
      pend_st_q <= pend_st_d;
      if (pend_st_q == ST_IDLE && pend_st_d == ST_STOP)
        pend_code_q <= trip_req_code;
      stop_req_q <= (pend_st_d == ST_STOP);
    end
  end

  ftm_timer u_heat (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (pend_st_q == ST_IDLE),
    .limit   (HEAT_LIM),
    .done_q  (heat_done)
  );

  // ****************************************************************
  // Candidate selection and arbitration
  // ****************************************************************

  // Undervoltage at power-up uses the restart level, later the threshold.
  assign uv_rise  = init_q ? dc_below_restart :
                    (dc_below_threshold && !undervoltage_condition_flag_q);
  assign uv_clear = !dc_below_restart && trip_active_q &&
                    active_trip_code_q == `FTM_C_DCLOW;

  // Fatal faults first, then a finished stop, then a direct trip, then UV.
  always @* begin
    cand_valid = 1'b0;
    cand_code  = `FTM_C_NONE;
    cand_class = `FTM_CL_SELF;
    cand_save  = 1'b0;
    if (fatal_hw_fault_trip) begin
      cand_valid = 1'b1;
      cand_class = `FTM_CL_FATAL;
    end else if (pend_fire) begin
      cand_valid = 1'b1;
      cand_code  = pend_code_q;
      cand_class = class_of(pend_code_q, !powerup_done);
    end else if (trip_req && !req_stop_first) begin
      cand_valid = 1'b1;
      cand_code  = trip_req_code;
      cand_class = class_of(trip_req_code, !powerup_done);
    end else if (uv_rise) begin
      cand_valid = 1'b1;
      cand_code  = `FTM_C_DCLOW;
      cand_save  = !init_q && !lv_supply_active_q;
    end
    accept = cand_valid &&
             (!trip_active_q || cand_class < active_class_q);
  end

  // ****************************************************************
  // Reset qualification
  // ****************************************************************

  // Hold-off runs from the latch; a reset before it ends is dropped.
  always @* begin
    case (active_class_q)
      `FTM_CL_FATAL:   reset_ok = 1'b0;
      `FTM_CL_NORESET: reset_ok = 1'b0;
      `FTM_CL_STORED:  reset_ok = defaults_seen_q;
      `FTM_CL_CARD:    reset_ok = hold_done;
      `FTM_CL_NORMAL:  reset_ok = hold_done;
      default:         reset_ok = 1'b0;
    endcase
  end

  ftm_timer u_hold (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (accept),
    .limit   (ext_hold_q ? HOLD_EXT : HOLD_STD),
    .done_q  (hold_done)
  );

  // ****************************************************************
  // Active trip register
  // ****************************************************************

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_active_q      <= 1'b0;
      active_trip_code_q <= `FTM_C_NONE;
      active_class_q     <= `FTM_CL_SELF;
      fatal_num_q        <= 4'h0;
      ext_hold_q         <= 1'b0;
      tune_trip_q        <= 1'b0;
      defaults_seen_q    <= 1'b0;
      param_save_q       <= 1'b0;
      init_q             <= 1'b1;
    end else begin
      init_q       <= 1'b0;
      param_save_q <= accept && cand_save;
      if (accept) begin
        trip_active_q      <= 1'b1;
        active_trip_code_q <= cand_code;
        active_class_q     <= cand_class;
        ext_hold_q         <= is_ext(cand_code);
        tune_trip_q        <= is_tune(cand_code);
        defaults_seen_q    <= 1'b0;
        if (cand_class == `FTM_CL_FATAL)
          fatal_num_q <= fatal_hw_num;
      end else if (uv_clear || (user_reset && trip_active_q && reset_ok)) begin
        trip_active_q      <= 1'b0;
        active_trip_code_q <= `FTM_C_NONE;
        active_class_q     <= `FTM_CL_SELF;
        ext_hold_q         <= 1'b0;
        tune_trip_q        <= 1'b0;
        defaults_seen_q    <= 1'b0;
      end else if (defaults_written) begin
        defaults_seen_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Supply state and outputs
  // ****************************************************************

  // The condition flag follows the bus with hysteresis; the supply source
  // is only switched while it is set, so the bus is never live on both.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      undervoltage_condition_flag_q <= 1'b0;
      lv_supply_active_q            <= 1'b0;
    end else begin
      if (uv_rise)
        undervoltage_condition_flag_q <= 1'b1;
      else if (!dc_below_restart)
        undervoltage_condition_flag_q <= 1'b0;
      if (undervoltage_condition_flag_q)
        lv_supply_active_q <= low_voltage_supply_select;
    end
  end

  // Any trip, including undervoltage, holds the output stage off; other functions
  // keep running, except that a fatal trip also opens the health relay and stops comms.
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_inhibit_q         <= 1'b0;
      output_stage_enable_q <= 1'b0;
      health_ok_q           <= 1'b0;
      comms_enable_q        <= 1'b0;
    end else begin
      if (user_reset && trip_active_q && reset_ok && tune_trip_q && !accept)
        run_inhibit_q <= 1'b1;
      else if (!enable_input || !output_enable_setting || !control_word_enable)
        run_inhibit_q <= 1'b0;
      output_stage_enable_q <= run_request && !trip_active_q && !accept &&
                               !run_inhibit_q && enable_input &&
                               output_enable_setting && control_word_enable;
      health_ok_q    <= !(trip_active_q && active_class_q == `FTM_CL_FATAL) &&
                        !(accept && cand_class == `FTM_CL_FATAL);
      comms_enable_q <= !(trip_active_q && active_class_q == `FTM_CL_FATAL) &&
                        !(accept && cand_class == `FTM_CL_FATAL);
    end
  end

endmodule // ftm_top

// ===== testbench/ftm_checker.sv
// Concurrent checks on the trip manager ports.
// Bound into ftm_top with its hold-off parameters.
`timescale 1ns/100ps
module ftm_checker #(
  parameter HOLD_STD_CYC = 20, // Short hold-off in cycles.
  parameter HOLD_EXT_CYC = 50  // Long hold-off in cycles.
) (
  input logic       sys_clk, sys_rst, trip_req, fatal_hw_fault_trip, user_reset,
  input logic       dc_below_restart, trip_active_q, health_ok_q, comms_enable_q,
  input logic       output_stage_enable_q, stop_req_q, undervoltage_condition_flag_q,
  input logic       lv_supply_active_q,
  input logic [1:0] trip_mode_setting,
  input logic [2:0] active_class_q,
  input logic [7:0] trip_req_code, active_trip_code_q
);
  // ********************
  // Hold-off age tracking
  // ********************
  logic [7:0] age_q;
  logic [7:0] last_q;
  wire  [31:0] lim = (active_trip_code_q inside {8'h03, 8'h04, 8'h67, 8'h68, 8'h6D}) ?
                     HOLD_EXT_CYC : HOLD_STD_CYC;
  // Age restarts on a new code, so a replacing trip waits anew.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_q  <= 8'h00;
      last_q <= 8'h00;
    end else begin
      last_q <= active_trip_code_q;
      age_q  <= (!trip_active_q || active_trip_code_q != last_q) ? 8'h00 :
                (age_q == 8'hFF) ? age_q : age_q + 8'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_fatal_out_off: assert property (
    trip_active_q && active_class_q == 3'h1 |=> !health_ok_q && !comms_enable_q)
    else $error("fatal trip left relay or comms on");
  chk_hard_no_reset: assert property (
    trip_active_q && active_class_q <= 3'h2 && user_reset |=>
    trip_active_q && active_class_q <= 3'h2) else $error("hard fault was reset");
  chk_uv_no_user: assert property (
    trip_active_q && active_trip_code_q == 8'h01 && dc_below_restart && user_reset
    |=> trip_active_q) else $error("undervoltage cleared by user reset");
  chk_trip_out_off: assert property (
    trip_active_q |-> !output_stage_enable_q) else $error("output on during trip");
  chk_equal_refused: assert property (
    trip_active_q && active_class_q == 3'h5 && trip_req && !user_reset && !stop_req_q
    && !fatal_hw_fault_trip && trip_req_code == active_trip_code_q
    |=> active_trip_code_q == $past(active_trip_code_q)) else $error("equal class taken");
  chk_early_reset: assert property (
    trip_active_q && active_class_q inside {3'h4, 3'h5} && user_reset
    && age_q + 4 < lim |=> trip_active_q) else $error("early reset honoured");
  chk_uv_auto_clear: assert property (
    trip_active_q && active_trip_code_q == 8'h01 && !dc_below_restart && !trip_req
    && !fatal_hw_fault_trip && !stop_req_q |=> !trip_active_q)
    else $error("undervoltage not cleared");
  chk_stop_first: assert property (
    !trip_active_q && !stop_req_q && trip_req && trip_req_code == 8'h18
    && trip_mode_setting[0] && !fatal_hw_fault_trip && !dc_below_restart
    |=> stop_req_q && !trip_active_q) else $error("no stop before trip");
  chk_lv_gate: assert property (
    !undervoltage_condition_flag_q && !$past(undervoltage_condition_flag_q)
    |-> $stable(lv_supply_active_q)) else $error("supply switched outside undervoltage");
endmodule // ftm_checker

bind ftm_top ftm_checker #(.HOLD_STD_CYC(HOLD_STD_CYC), .HOLD_EXT_CYC(HOLD_EXT_CYC)) u_chk (
  .sys_clk, .sys_rst, .trip_req, .user_reset, .fatal_hw_fault_trip, .dc_below_restart,
  .trip_active_q, .health_ok_q, .comms_enable_q, .output_stage_enable_q, .stop_req_q,
  .undervoltage_condition_flag_q, .lv_supply_active_q, .trip_mode_setting,
  .active_class_q, .trip_req_code, .active_trip_code_q);

// ===== testbench/ftm_partner.sv
// Far side: user reset source and serial master reading the code.
// Driven by bench tasks; requests change on the falling edge.
`timescale 1ns/100ps
module ftm_partner (
  input  logic       sys_clk,    // System clock.
  input  logic [7:0] trip_code,  // Active trip code from the block.
  output logic       user_reset, // One-cycle reset request.
  output logic [7:0] read_code   // Code last read over the link.
);
  // Idle until asked.
  initial begin
    user_reset = 1'b0;
    read_code  = 8'h00;
  end
  // A reset request spans one rising edge.
  task send_reset;
    @(negedge sys_clk) user_reset = 1'b1;
    @(negedge sys_clk) user_reset = 1'b0;
  endtask
  // Read between edges, where the code is settled.
  task poll;
    @(negedge sys_clk) read_code = trip_code;
  endtask
endmodule // ftm_partner

// ===== testbench/ftm_top_tb_top.sv
// Self-checking bench for the trip manager, one task per scenario.
// Short hold-off and overheat counts keep the run brief.
`timescale 1ns/100ps
`define CHK(a, e, m) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t %s", $time, m); end end
module ftm_top_tb_top;
  localparam STD = 20, EXT = 50, HEAT = 30;
  logic sys_clk, sys_rst, trip_req, fatal_hw_fault_trip, user_reset, defaults_written;
  logic motor_stopped, powerup_done, dc_below_threshold, dc_below_restart, run_request;
  logic low_voltage_supply_select, enable_input, output_enable_setting, control_word_enable;
  logic trip_active_q, health_ok_q, comms_enable_q, output_stage_enable_q, stop_req_q;
  logic param_save_q, undervoltage_condition_flag_q, lv_supply_active_q, run_inhibit_q;
  logic [1:0] trip_mode_setting;
  logic [2:0] active_class_q;
  logic [3:0] fatal_hw_num, fatal_num_q;
  logic [7:0] trip_req_code, active_trip_code_q, read_code;
  integer error_cnt = 0, num_checks = 0, saves = 0;
  ftm_top #(.HOLD_STD_CYC(STD), .HOLD_EXT_CYC(EXT), .HEAT_CYC(HEAT)) uut (
    .sys_clk, .sys_rst, .trip_req, .trip_req_code, .fatal_hw_fault_trip, .fatal_hw_num,
    .user_reset, .defaults_written, .trip_mode_setting, .motor_stopped, .powerup_done,
    .dc_below_threshold, .dc_below_restart, .low_voltage_supply_select, .enable_input,
    .output_enable_setting, .control_word_enable, .run_request, .trip_active_q,
    .active_trip_code_q, .active_class_q, .fatal_num_q, .health_ok_q, .comms_enable_q,
    .output_stage_enable_q, .stop_req_q, .param_save_q, .run_inhibit_q,
    .undervoltage_condition_flag_q, .lv_supply_active_q);
  ftm_partner u_host (.sys_clk, .trip_code(active_trip_code_q), .user_reset, .read_code);
  // ********************
  // Clock, save counting and helpers
  // ********************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Count save pulses between edges.
  always @(negedge sys_clk) if (param_save_q === 1'b1) saves++;
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task pwr;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(2);
  endtask
  task dc(input logic [1:0] v);
    {dc_below_threshold, dc_below_restart} = v;
  endtask
  task trip(input logic [7:0] c);
    @(negedge sys_clk) trip_req = 1'b1;
    trip_req_code = c;
    @(negedge sys_clk) trip_req = 1'b0;
  endtask
  task see(input logic [7:0] c, input logic a, input string m);
    u_host.poll();
    `CHK(read_code, c, m)
    `CHK(trip_active_q, a, m)
  endtask
  // Power-up below restart level, then the bus recovers.
  task s_pu;
    dc(2'b11);
    saves = 0;
    pwr();
    see(8'h01, 1'b1, "no power-up undervoltage");
    `CHK(saves, 0, "save at power-up")
    dc(2'b00);
    cyc(2);
    see(8'h00, 1'b0, "undervoltage kept");
    low_voltage_supply_select = 1'b1;
    cyc(2);
    `CHK({lv_supply_active_q, output_stage_enable_q}, 2'b01, "supply or output")
  endtask
  // Runtime undervoltage: saves, user reset, supply switch, replacement.
  task s_uv;
    low_voltage_supply_select = 1'b0;
    saves = 0;
    dc(2'b11);
    cyc(3);
    see(8'h01, 1'b1, "undervoltage missing");
    `CHK(saves, 1, "save count")
    `CHK(output_stage_enable_q, 1'b0, "output on in undervoltage")
    `CHK(undervoltage_condition_flag_q, 1'b1, "flag low")
    u_host.send_reset();
    see(8'h01, 1'b1, "undervoltage reset by user");
    low_voltage_supply_select = 1'b1;
    cyc(2);
    `CHK(lv_supply_active_q, 1'b1, "supply not switched")
    dc(2'b00);
    cyc(2);
    dc(2'b11);
    cyc(3);
    `CHK(saves, 1, "save in low voltage mode")
    trip(8'h09);
    see(8'h09, 1'b1, "undervoltage shown over other trip");
    dc(2'b00);
    cyc(2);
    see(8'h09, 1'b1, "other trip auto cleared");
  endtask
  // Extended hold-off, equal class refusal, normal hold-off.
  task s_oc;
    pwr();
    trip(8'h03);
    trip(8'h03);
    trip(8'h1C);
    see(8'h03, 1'b1, "equal class replaced");
    `CHK(active_class_q, 3'h5, "overcurrent class")
    cyc(20);
    u_host.send_reset();
    see(8'h03, 1'b1, "early reset honoured");
    cyc(32);
    u_host.send_reset();
    see(8'h00, 1'b0, "late reset ignored");
    trip(8'h1E);
    cyc(8);
    u_host.send_reset();
    see(8'h1E, 1'b1, "early normal reset");
    cyc(15);
    u_host.send_reset();
    see(8'h00, 1'b0, "normal reset ignored");
  endtask
  // Card trip class during and after power-up.
  task s_card(input logic done, input logic [7:0] win);
    pwr();
    powerup_done = done;
    trip(8'hAF);
    `CHK(active_class_q, done ? 3'h4 : 3'h5, "card class")
    trip(8'h09);
    see(win, 1'b1, "card versus supply arbitration");
  endtask
  // Non-resettable then fatal fault.
  task s_hard;
    pwr();
    trip(8'hD9);
    cyc(30);
    u_host.send_reset();
    see(8'hD9, 1'b1, "class two reset");
    @(negedge sys_clk) fatal_hw_fault_trip = 1'b1;
    fatal_hw_num = 4'h4;
    @(negedge sys_clk) fatal_hw_fault_trip = 1'b0;
    u_host.send_reset();
    cyc(1);
    `CHK({active_class_q, fatal_num_q}, {3'h1, 4'h4}, "fatal latch")
    `CHK({health_ok_q, comms_enable_q, trip_active_q}, 3'b001, "fatal outputs")
  endtask
  // Stored parameter fault needs defaults before reset.
  task s_eef;
    pwr();
    trip(8'h1F);
    cyc(30);
    u_host.send_reset();
    see(8'h1F, 1'b1, "stored fault reset without defaults");
    @(negedge sys_clk) defaults_written = 1'b1;
    @(negedge sys_clk) defaults_written = 1'b0;
    u_host.send_reset();
    see(8'h00, 1'b0, "stored fault kept after defaults");
  endtask
  // Stop-before-trip: sensor, phase loss, overheat.
  task s_stop(input logic [7:0] c, input integer wait_n, input logic stops);
    pwr();
    trip_mode_setting = 2'h1;
    motor_stopped = 1'b0;
    trip(c);
    cyc(wait_n);
    `CHK({stop_req_q, trip_active_q}, 2'b10, "no stop before trip")
    motor_stopped = stops;
    cyc(stops ? 2 : 15);
    see(c, 1'b1, "stop trip not latched");
  endtask
  // Autotune reset blocks running until disabled.
  task s_tune;
    pwr();
    trip(8'h0B);
    cyc(25);
    u_host.send_reset();
    cyc(1);
    `CHK({trip_active_q, run_inhibit_q, output_stage_enable_q}, 3'b010, "tune inhibit")
    enable_input = 1'b0;
    cyc(2);
    `CHK(run_inhibit_q, 1'b0, "inhibit kept after disable")
  endtask
  // Verdict and end of run.
  task summarize;
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: inputs set at time zero, then scenarios.
  initial begin
    {trip_req, fatal_hw_fault_trip, defaults_written, motor_stopped} = 4'h0;
    {dc_below_threshold, dc_below_restart, low_voltage_supply_select} = 3'h0;
    {powerup_done, enable_input, output_enable_setting, control_word_enable} = 4'hF;
    {run_request, trip_mode_setting, fatal_hw_num, trip_req_code} = 15'h4000;
    s_pu();
    s_uv();
    s_oc();
    s_card(1'b1, 8'hAF);
    s_card(1'b0, 8'h09);
    s_hard();
    s_eef();
    s_stop(8'h18, 5, 1'b1);
    s_stop(8'h20, HEAT + 5, 1'b1);
    s_stop(8'h1B, HEAT - 10, 1'b0);
    s_tune();
    summarize();
  end
  // Watchdog far past the expected run.
  initial begin
    #500000;
    error_cnt++;
    summarize();
  end
endmodule // ftm_top_tb_top
